// *** core/omcs_params.svh ***
// Offsets, field positions, reset values and timing counts
`ifndef OMCS_PARAMS_SVH
`define OMCS_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define OMCS_CLK_HZ 25000000
`define OMCS_T_INIT_MS 300
// Divided first so the product fits in 32 bits
`define OMCS_T_INIT_CYC (`OMCS_T_INIT_MS * (`OMCS_CLK_HZ / 1000))
`define OMCS_T_RESET_US 10
// Least time, rounded up
`define OMCS_T_RESET_CYC \
  ((`OMCS_T_RESET_US * `OMCS_CLK_HZ + 999999) / 1000000)

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OMCS_REG_CTRL 8'h00
`define OMCS_REG_STATUS 8'h04
`define OMCS_REG_IRQ_STAT 8'h08
`define OMCS_REG_IRQ_EN 8'h0C
`define OMCS_REG_IRQ_CLR 8'h10
`define OMCS_REG_DIAG_TV 8'h14
`define OMCS_REG_DIAG_BT 8'h18
`define OMCS_REG_DIAG_RX 8'h1C
`define OMCS_REG_ID_ADDR 8'h20
`define OMCS_REG_ID_DATA 8'h24

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define OMCS_CTRL_SOFT_DIS 0
`define OMCS_CTRL_CAL_EXT 1
`define OMCS_CTRL_RST 2'h0
`define OMCS_ST_FAULT 0
`define OMCS_ST_DISABLE 1
`define OMCS_ST_LOST 2
`define OMCS_ST_INIT_DONE 3
`define OMCS_ST_LASER_ON 4
`define OMCS_IRQ_FAULT 0
`define OMCS_IRQ_LOST_SET 1
`define OMCS_IRQ_LOST_CLR 2
`define OMCS_IRQ_SER_RD 3
`define OMCS_IRQ_W 4

// ----------------------------------------------------------------
// Serial memory layout
// ----------------------------------------------------------------
`define OMCS_TWI_DEV_ADDR 7'h50
`define OMCS_DIAG_BASE 8'h80
`define OMCS_DIAG_FLAGS 8'h8A
`define OMCS_RESP_OKAY 2'h0
`define OMCS_RESP_DECERR 2'h3

`endif

// *** core/omcs_pkg.sv ***
// Types shared by the optical module control and status block
package omcs_pkg;
  // Serial slave phases
  typedef enum logic [2:0] {
    TWI_IDLE, TWI_ADDR, TWI_AACK, TWI_PTR, TWI_PACK, TWI_READ, TWI_RACK
  } omcs_twi_state_t;
  // Bus response code
  typedef logic [1:0] omcs_resp_t;
  // Register byte address
  typedef logic [7:0] omcs_addr_t;
endpackage : omcs_pkg

// *** core/omcs_twi_slave.sv ***
// Two-wire serial slave serving module memory reads
`timescale 1ns/10ps
`include "omcs_params.svh"
module omcs_twi_slave #(
  parameter logic [6:0] DEV_ADDR = `OMCS_TWI_DEV_ADDR
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic scl_i, // Bus clock pin
  input wire logic sda_i, // Bus data pin level
  output logic sda_o, // Data drive level, always low
  output logic sda_oe, // High while pulling data low
  output logic [7:0] mem_addr, // Byte pointer
  input wire logic [7:0] mem_rdata, // Byte at pointer
  output logic rd_done // Pulse per byte sent
);
  import omcs_pkg::*;

  logic [1:0] scl_meta_q, sda_meta_q; // First two sync stages
  logic [1:0] scl_s_q, sda_s_q; // Synced, and one older
  omcs_twi_state_t st_q;
  logic [3:0] cnt_q; // Bits moved this byte
  logic [7:0] sh_q; // Input shifter
  logic [7:0] out_q; // Output shifter
  logic rw_q; // Read requested
  logic nack_q; // Host refused more data
  logic scl_rise, scl_fall, start_c, stop_c;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_meta_q <= 2'h3;
      sda_meta_q <= 2'h3;
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
    end else begin
      scl_meta_q <= {scl_meta_q[0], scl_i};
      sda_meta_q <= {sda_meta_q[0], sda_i};
      scl_s_q <= {scl_s_q[0], scl_meta_q[1]};
      sda_s_q <= {sda_s_q[0], sda_meta_q[1]};
    end
  end

  // Edges seen only on the synced copies
  assign scl_rise = scl_s_q[0] && !scl_s_q[1];
  assign scl_fall = !scl_s_q[0] && scl_s_q[1];
  assign start_c = scl_s_q[0] && scl_s_q[1] && !sda_s_q[0] && sda_s_q[1];
  assign stop_c = scl_s_q[0] && scl_s_q[1] && sda_s_q[0] && !sda_s_q[1];
  assign sda_o = 1'b0;

  // ----------------------------------------------------------------
  // Protocol engine; data changes only while the clock is low
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    rd_done <= 1'b0;
    if (!aresetn) begin
      st_q <= TWI_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      out_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe <= 1'b0;
      mem_addr <= 8'h00;
    end else if (stop_c) begin
      st_q <= TWI_IDLE;
      sda_oe <= 1'b0;
    end else if (start_c) begin // Repeated start is allowed too
      st_q <= TWI_ADDR;
      cnt_q <= 4'h0;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      unique case (st_q)
        TWI_ADDR, TWI_PTR: begin
          sh_q <= {sh_q[6:0], sda_s_q[0]};
          cnt_q <= cnt_q + 4'h1;
        end
        TWI_READ: cnt_q <= cnt_q + 4'h1;
        TWI_RACK: nack_q <= sda_s_q[0];
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (st_q)
        TWI_ADDR: if (cnt_q == 4'h8) begin
          if (sh_q[7:1] == DEV_ADDR) begin
            rw_q <= sh_q[0];
            st_q <= TWI_AACK;
            sda_oe <= 1'b1;
          end else begin
            st_q <= TWI_IDLE; // Other device addressed
          end
        end
        TWI_AACK: begin
          cnt_q <= 4'h0;
          if (rw_q) begin
            out_q <= mem_rdata;
            sda_oe <= !mem_rdata[7];
            st_q <= TWI_READ;
          end else begin
            sda_oe <= 1'b0;
            st_q <= TWI_PTR;
          end
        end
        TWI_PTR: if (cnt_q == 4'h8) begin
          mem_addr <= sh_q; // Later bytes also move the pointer
          sda_oe <= 1'b1;
          st_q <= TWI_PACK;
        end
        TWI_PACK: begin
          sda_oe <= 1'b0;
          cnt_q <= 4'h0;
          st_q <= TWI_PTR;
        end
        TWI_READ: begin
          if (cnt_q == 4'h8) begin
            sda_oe <= 1'b0; // Let the host acknowledge
            mem_addr <= mem_addr + 8'h01;
            rd_done <= 1'b1;
            st_q <= TWI_RACK;
          end else begin
            out_q <= {out_q[6:0], 1'b0};
            sda_oe <= !out_q[6];
          end
        end
        TWI_RACK: begin
          cnt_q <= 4'h0;
          if (nack_q) begin
            st_q <= TWI_IDLE;
          end else begin
            out_q <= mem_rdata;
            sda_oe <= !mem_rdata[7];
            st_q <= TWI_READ;
          end
        end
        default: ;
      endcase
    end
  end
endmodule : omcs_twi_slave

// *** core/omcs_top.sv ***
// Optical module control, status pins and register slave
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`include "omcs_params.svh"
module omcs_top #(
  parameter int unsigned INIT_CYC = `OMCS_T_INIT_CYC, // Init length
  parameter logic [6:0] TWI_ADDR = `OMCS_TWI_DEV_ADDR, // Serial address
  parameter int unsigned ID_DEPTH = 128 // Identification bytes
) (
  input wire logic aclk, // System clock, 25 MHz
  input wire logic aresetn, // Sync reset, active low
  input wire omcs_pkg::omcs_addr_t s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output omcs_pkg::omcs_resp_t s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire omcs_pkg::omcs_addr_t s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output omcs_pkg::omcs_resp_t s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic tx_disable_i, // Shutdown pin, pulled high in pad
  input wire logic laser_fault_i, // Laser driver fault, async
  input wire logic rx_lost_i, // Receiver power detector, async
  output logic laser_on, // Transmitter enable to driver
  output logic tx_fault_o, // Fault pin drive level
  output logic tx_fault_oe, // Fault pin pull-low enable
  output logic receive_signal_lost_o, // Loss pin drive level
  output logic receive_signal_lost_oe, // Loss pin pull-low enable
  output logic present_o, // Presence pin drive level
  output logic present_oe, // Presence pin pull-low enable
  input wire logic scl_i, // Serial clock pin
  input wire logic sda_i, // Serial data pin level
  output logic sda_o, // Serial data drive level
  output logic sda_oe, // Serial data pull-low enable
  output logic irq // Level interrupt
);
  import omcs_pkg::*;

  localparam int unsigned RST_CYC = `OMCS_T_RESET_CYC;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge of a bus write
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // Known register offset
  function automatic logic mapped(input omcs_addr_t a);
    return a == `OMCS_REG_CTRL || a == `OMCS_REG_STATUS ||
      a == `OMCS_REG_IRQ_STAT || a == `OMCS_REG_IRQ_EN ||
      a == `OMCS_REG_IRQ_CLR || a == `OMCS_REG_DIAG_TV ||
      a == `OMCS_REG_DIAG_BT || a == `OMCS_REG_DIAG_RX ||
      a == `OMCS_REG_ID_ADDR || a == `OMCS_REG_ID_DATA;
  endfunction : mapped

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [2:0] meta_q; // First sync stage of pins
  logic [2:0] sync_q; // {lost, fault, disable} synced
  logic dis_prev_q; // Disable one cycle older
  logic lost_prev_q; // Loss one cycle older
  logic [22:0] init_cnt_q; // Power-up timer
  logic init_done_q; // Power-up finished
  logic [8:0] dis_cnt_q; // Length of shutdown pulse
  logic fault_q; // Latched laser fault
  logic [1:0] ctrl_q; // Soft disable, external cal
  logic [31:0] diag_tv_q, diag_bt_q, diag_rx_q; // Live readings
  logic [6:0] id_ptr_q; // Identification write pointer
  logic [7:0] id_mem [ID_DEPTH]; // Identification bytes
  logic [`OMCS_IRQ_W-1:0] irq_stat_q, irq_en_q; // Events, gate
  logic [`OMCS_IRQ_W-1:0] ev; // Events this cycle
  logic [`OMCS_IRQ_W-1:0] clr_w; // Clear written this cycle
  logic aw_hold_q, w_hold_q; // Write halves captured
  omcs_addr_t aw_q; // Captured write address
  logic [31:0] wd_q; // Captured write data
  logic [3:0] ws_q; // Captured byte enables
  logic do_wr; // Write commits now
  logic [7:0] twi_addr, twi_rdata; // Serial memory port
  logic twi_rd; // Serial byte sent
  logic fault_clr; // Shutdown pulse completed

  // ----------------------------------------------------------------
  // Pin synchronisers; only the second stage is used
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 3'h1; // Disable idles high as if open
      sync_q <= 3'h1;
      dis_prev_q <= 1'b1;
      lost_prev_q <= 1'b0;
    end else begin
      meta_q <= {rx_lost_i, laser_fault_i, tx_disable_i};
      sync_q <= meta_q;
      dis_prev_q <= sync_q[0];
      lost_prev_q <= sync_q[2];
    end
  end

  // ----------------------------------------------------------------
  // Power-up timer; laser and fault held quiet until done
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_cnt_q <= 23'h0;
      init_done_q <= 1'b0;
    end else if (!init_done_q) begin
      init_cnt_q <= init_cnt_q + 23'h1;
      if (init_cnt_q >= 23'(INIT_CYC - 1)) init_done_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Fault latch; cleared by a long enough shutdown pulse
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dis_cnt_q <= 9'h0;
    end else if (!sync_q[0]) begin
      dis_cnt_q <= 9'h0;
    end else if (dis_cnt_q < 9'(RST_CYC)) begin
      dis_cnt_q <= dis_cnt_q + 9'h1; // Saturates at the minimum
    end
  end

  // Falling shutdown after the minimum high time
  assign fault_clr = dis_prev_q && !sync_q[0] &&
    dis_cnt_q >= 9'(RST_CYC);

  // Set wins: a fault still present re-latches at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_q <= 1'b0;
    end else if (init_done_q && sync_q[1]) begin
      fault_q <= 1'b1;
    end else if (fault_clr) begin
      fault_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers: laser enable, and status pins open-drain pulling low
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      laser_on <= 1'b0;
      tx_fault_oe <= 1'b1;
      receive_signal_lost_oe <= 1'b1;
    end else begin
      // One synced cycle to dark, far inside 10 us
      laser_on <= init_done_q && !sync_q[0] && !fault_q &&
        !ctrl_q[`OMCS_CTRL_SOFT_DIS];
      tx_fault_oe <= !fault_q;
      receive_signal_lost_oe <= !sync_q[2];
    end
  end

  assign tx_fault_o = 1'b0;
  assign receive_signal_lost_o = 1'b0;
  assign present_o = 1'b0;
  assign present_oe = 1'b1;

  // ----------------------------------------------------------------
  // Serial memory: identification below 0x80, live data above
  // ----------------------------------------------------------------
  always_comb begin
    twi_rdata = 8'h00;
    if (!twi_addr[7]) begin
      twi_rdata = id_mem[twi_addr[6:0]];
    end else begin
      unique case (twi_addr - `OMCS_DIAG_BASE)
        8'h00: twi_rdata = diag_tv_q[31:24]; // Temperature
        8'h01: twi_rdata = diag_tv_q[23:16];
        8'h02: twi_rdata = diag_tv_q[15:8]; // Supply
        8'h03: twi_rdata = diag_tv_q[7:0];
        8'h04: twi_rdata = diag_bt_q[31:24]; // Bias
        8'h05: twi_rdata = diag_bt_q[23:16];
        8'h06: twi_rdata = diag_bt_q[15:8]; // Transmit power
        8'h07: twi_rdata = diag_bt_q[7:0];
        8'h08: twi_rdata = diag_rx_q[15:8]; // Receive power
        8'h09: twi_rdata = diag_rx_q[7:0];
        8'h0A: twi_rdata = {4'h0, sync_q[0], sync_q[2], fault_q,
          ctrl_q[`OMCS_CTRL_CAL_EXT]};
        default: twi_rdata = 8'h00;
      endcase
    end
  end

  // Host clocks the bus; 400 kHz is far below our sampling rate
  omcs_twi_slave #(.DEV_ADDR(TWI_ADDR)) u_twi (
    .aclk(aclk),
    .aresetn(aresetn),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .mem_addr(twi_addr),
    .mem_rdata(twi_rdata),
    .rd_done(twi_rd)
  );

  // ----------------------------------------------------------------
  // Bus write channel: halves captured in either order
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign do_wr = aw_hold_q && w_hold_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_q <= 8'h00;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `OMCS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_q) ? `OMCS_RESP_OKAY : `OMCS_RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `OMCS_CTRL_RST;
      irq_en_q <= '0;
      diag_tv_q <= 32'h0;
      diag_bt_q <= 32'h0;
      diag_rx_q <= 32'h0;
      id_ptr_q <= 7'h0;
    end else if (do_wr) begin
      unique case (aw_q)
        `OMCS_REG_CTRL: ctrl_q <= 2'(merge(32'(ctrl_q), wd_q, ws_q));
        `OMCS_REG_IRQ_EN: irq_en_q <= `OMCS_IRQ_W'(merge(32'(irq_en_q),
          wd_q, ws_q));
        `OMCS_REG_DIAG_TV: diag_tv_q <= merge(diag_tv_q, wd_q, ws_q);
        `OMCS_REG_DIAG_BT: diag_bt_q <= merge(diag_bt_q, wd_q, ws_q);
        `OMCS_REG_DIAG_RX: diag_rx_q <= merge(diag_rx_q, wd_q, ws_q);
        `OMCS_REG_ID_ADDR: if (ws_q[0]) id_ptr_q <= wd_q[6:0];
        `OMCS_REG_ID_DATA: if (ws_q[0]) id_ptr_q <= id_ptr_q + 7'h1;
        default: ;
      endcase
    end
  end

  // Identification store, filled by software one byte at a time
  always_ff @(posedge aclk) begin
    if (do_wr && aw_q == `OMCS_REG_ID_DATA && ws_q[0]) begin
      id_mem[id_ptr_q] <= wd_q[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupts: sticky events, set wins over clear
  // ----------------------------------------------------------------
  assign ev[`OMCS_IRQ_FAULT] = init_done_q && sync_q[1] && !fault_q;
  assign ev[`OMCS_IRQ_LOST_SET] = sync_q[2] && !lost_prev_q;
  assign ev[`OMCS_IRQ_LOST_CLR] = !sync_q[2] && lost_prev_q;
  assign ev[`OMCS_IRQ_SER_RD] = twi_rd;
  assign clr_w = (do_wr && aw_q == `OMCS_REG_IRQ_CLR && ws_q[0]) ?
    wd_q[`OMCS_IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~clr_w) | ev;
      irq <= |(irq_stat_q & irq_en_q);
    end
  end

  // ----------------------------------------------------------------
  // Bus read channel: answer one cycle after the address
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `OMCS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? `OMCS_RESP_OKAY :
        `OMCS_RESP_DECERR;
      unique case (s_axi_araddr)
        `OMCS_REG_CTRL: s_axi_rdata <= 32'(ctrl_q);
        `OMCS_REG_STATUS: s_axi_rdata <= 32'({laser_on, init_done_q,
          sync_q[2], sync_q[0], fault_q});
        `OMCS_REG_IRQ_STAT: s_axi_rdata <= 32'(irq_stat_q);
        `OMCS_REG_IRQ_EN: s_axi_rdata <= 32'(irq_en_q);
        `OMCS_REG_DIAG_TV: s_axi_rdata <= diag_tv_q;
        `OMCS_REG_DIAG_BT: s_axi_rdata <= diag_bt_q;
        `OMCS_REG_DIAG_RX: s_axi_rdata <= diag_rx_q;
        `OMCS_REG_ID_ADDR: s_axi_rdata <= 32'(id_ptr_q);
        default: s_axi_rdata <= 32'h0; // Clear, data and holes
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : omcs_top

// *** bench/omcs_monitor.sv ***
// Concurrent checks on the pins and register bus
`timescale 1ns/10ps
module omcs_monitor (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire omcs_pkg::omcs_resp_t s_axi_bresp, // Write response
  input wire logic tx_disable_i, // Shutdown pin
  input wire logic rx_lost_i, // Loss detector
  input wire logic laser_on, // Transmitter enable
  input wire logic tx_fault_o, // Fault pin level
  input wire logic tx_fault_oe, // Fault pin pull-low
  input wire logic receive_signal_lost_o, // Loss pin level
  input wire logic receive_signal_lost_oe, // Loss pin pull-low
  input wire logic present_o, // Presence pin level
  input wire logic present_oe, // Presence pin pull-low
  input wire logic sda_o // Serial data level
);
  // ----------------------------------------------------------------
  // Checks, one clock domain
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_present_grounded: assert property (present_oe && !present_o)
    else $error("presence not grounded");
  // Open-drain pins only pull low
  a_pins_pull_low: assert property (!tx_fault_o && !receive_signal_lost_o
    && !sda_o)
    else $error("pin driven high");
  a_shutdown_dark: assert property (tx_disable_i [*6] |-> !laser_on)
    else $error("laser lit in shutdown");
  a_fault_dark: assert property (!tx_fault_oe [*2] |-> !laser_on)
    else $error("laser lit with fault");
  a_loss_raised: assert property (rx_lost_i [*5] |->
    !receive_signal_lost_oe)
    else $error("loss pin not raised");
  a_loss_cleared: assert property (!rx_lost_i [*5] |->
    receive_signal_lost_oe)
    else $error("loss pin not cleared");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer late");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  c_fault_seen: cover property ($fell(tx_fault_oe));
  c_loss_seen: cover property ($fell(receive_signal_lost_oe));
  c_bad_write: cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
endmodule : omcs_monitor

bind omcs_top omcs_monitor u_mon (.*);

// *** bench/omcs_host_model.sv ***
// Two-wire bus master standing in for the host
`timescale 1ns/10ps
module omcs_host_model #(
  parameter int HALF = 32, // Clock high time; low time is 4 more, 368 kHz at 25 MHz
  parameter logic [6:0] DEV = 7'h50 // Serial device address
) (
  input wire logic aclk, // System clock
  input wire logic sda, // Data line level, pulled up
  output logic scl, // Bus clock, idle high
  output logic sda_low // High while pulling data low
);
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  // Clock within the rate limit
  task automatic hw;
    repeat (HALF) @(posedge aclk);
  endtask : hw
  // Data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    repeat (4) @(posedge aclk);
    sda_low <= !b;
    hw();
    scl <= 1'h1;
    hw();
    r = sda;
    scl <= 1'h0;
  endtask : bit_io
  task automatic start_c;
    sda_low <= 1'h0;
    hw();
    scl <= 1'h1;
    hw();
    sda_low <= 1'h1;
    hw();
    scl <= 1'h0;
  endtask : start_c
  task automatic byte_io(input logic [7:0] o, input logic a,
      output logic [7:0] i, output logic ak);
    for (int k = 7; k >= 0; k--) begin
      bit_io(o[k], i[k]);
    end
    bit_io(a, ak);
  endtask : byte_io
  // Pointer write, restart, read one byte, stop
  task automatic read_byte(input logic [7:0] p, output logic [7:0] d,
      output logic nak);
    logic [7:0] x;
    logic n0, n1, n2;
    start_c();
    byte_io({DEV, 1'h0}, 1'h1, x, n0);
    byte_io(p, 1'h1, x, n1);
    start_c();
    byte_io({DEV, 1'h1}, 1'h1, x, n2);
    byte_io(8'hFF, 1'h1, d, x[0]);
    hw();
    sda_low <= 1'h1;
    hw();
    scl <= 1'h1;
    hw();
    sda_low <= 1'h0;
    hw();
    nak = n0 | n1 | n2;
  endtask : read_byte
endmodule : omcs_host_model

// *** bench/tb_optical_module_control_status.sv ***
// Self-checking bench for the control and status block
`timescale 1ns/10ps
`include "omcs_params.svh"
module tb_optical_module_control_status;
  import omcs_pkg::*;
  typedef struct packed {
    logic w; omcs_addr_t a; logic [31:0] d; omcs_resp_t r;
  } omcs_row_t;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic tx_disable_i = 1, laser_fault_i = 0, rx_lost_i = 0, sda_low;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, got;
  logic [3:0] s_axi_wstrb = 4'hF;
  omcs_addr_t s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, laser_on, tx_fault_o, tx_fault_oe, present_o;
  logic receive_signal_lost_o, receive_signal_lost_oe, present_oe;
  logic scl_i, sda_i, sda_o, sda_oe, irq, nak;
  omcs_resp_t s_axi_bresp, s_axi_rresp, rsp;
  int bad_count = 0, num_checks = 0, cyc = 0;
  // Rows: data to write, or data expected back
  omcs_row_t rows [12] = '{'{1, `OMCS_REG_CTRL, 3, 0},
    '{0, `OMCS_REG_CTRL, 3, 0}, '{1, `OMCS_REG_IRQ_EN, 8, 0},
    '{0, `OMCS_REG_IRQ_EN, 8, 0}, '{0, `OMCS_REG_IRQ_CLR, 0, 0},
    '{1, 8'h40, 5, 3}, '{0, 8'h40, 0, 3}, '{1, `OMCS_REG_ID_ADDR, 5, 0},
    '{1, `OMCS_REG_ID_DATA, 32'hA5, 0}, '{0, `OMCS_REG_ID_DATA, 0, 0},
    '{1, `OMCS_REG_CTRL, 0, 0}, '{0, `OMCS_REG_CTRL, 0, 0}};
  omcs_top #(.INIT_CYC(20)) u_dut (.*);
  omcs_host_model u_host (.aclk(aclk), .sda(sda_i), .scl(scl_i),
    .sda_low(sda_low));
  assign sda_i = !(sda_low || sda_oe); // Open-drain line with pull-up
  initial forever #20 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // One bus transfer
  task automatic xfer(input logic w, input omcs_addr_t a,
      input logic [31:0] wd, output logic [31:0] rd, output omcs_resp_t r);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!(w ? s_axi_bvalid : s_axi_rvalid));
    rd = s_axi_rdata;
    r = w ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 0;
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask : xfer
  // Shutdown pulse of n cycles
  task automatic pulse(input int n);
    tx_disable_i <= 1;
    repeat (n) @(posedge aclk);
    chk(laser_on, 0);
    tx_disable_i <= 0;
    repeat (12) @(posedge aclk);
  endtask : pulse
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  initial begin
    repeat (6) @(posedge aclk);
    chk({laser_on, tx_fault_oe, s_axi_bvalid, irq}, 4'h4);
    aresetn <= 1;
    foreach (rows[i]) begin
      xfer(rows[i].w, rows[i].a, rows[i].d, got, rsp);
      chk(rsp, rows[i].r);
      if (!rows[i].w) chk(got, rows[i].d);
    end
    xfer(0, `OMCS_REG_STATUS, 0, got, rsp);
    chk(got, 32'hA);
    pulse(8);
    chk(laser_on, 1);
    laser_fault_i <= 1;
    repeat (8) @(posedge aclk);
    chk({tx_fault_oe, laser_on, irq}, 0);
    laser_fault_i <= 0;
    pulse(100);
    chk(tx_fault_oe, 0);
    pulse(260);
    chk({tx_fault_oe, laser_on}, 3);
    rx_lost_i <= 1;
    repeat (6) @(posedge aclk);
    chk(receive_signal_lost_oe, 0);
    rx_lost_i <= 0;
    repeat (6) @(posedge aclk);
    u_host.read_byte(8'h05, got[7:0], nak);
    chk({nak, got[7:0]}, 9'h0A5);
    xfer(0, `OMCS_REG_IRQ_STAT, 0, got, rsp);
    chk(got, 32'hF);
    chk(irq, 1);
    xfer(1, `OMCS_REG_IRQ_CLR, 32'hF, got, rsp);
    repeat (3) @(posedge aclk);
    chk(irq, 0);
    close_out();
  end
endmodule : tb_optical_module_control_status
